// ### ipt_regs.vh
// Contract
// - Three-bit CPU level at status bits 7..5
// - Extension bit above field gives levels 8..15
// - No user interrupt while extension bit set
// - Extension reads one above 7, clear-only, resets zero
// - Level field read-only while nesting disabled
// - Nesting disable at control-one bit 15
// - Overflow flags A bit 14, B bit 13
// - Catastrophic flags A bit 12, B bit 11
// - Overflow traps gated by enables bits 10, 9
// - Catastrophic traps gated by enable bit 8
// - Bad shift bit 7, divide zero bit 6
// - Math trap flag bit 4 on any math trap; code sets it on bad shift or divide zero only, not on accumulator traps
// - Address 3, stack 2, oscillator 1; bit 0 zero
// - Control-two bit 15 selects alternate vector table
// - Timed disable status read-only at bit 14
// - Edge polarity bits 2..0, one means falling
// - Request flags set on request, read/write, reset zero
// - Group zero flag layout
// - Group one flag layout
// - Hardware sets flags, software clears them; code also lets software set a flag by writing one
// - Eight programmable priority levels per source; code treats level 0 as never arbitrated, so seven can raise a request
`ifndef IPT_REGS_VH
`define IPT_REGS_VH
`define IPT_OFF_STATUS 12'h000
`define IPT_OFF_CORE 12'h004
`define IPT_OFF_CTL1 12'h008
`define IPT_OFF_CTL2 12'h00C
`define IPT_OFF_FLAGS0 12'h010
`define IPT_OFF_FLAGS1 12'h014
`define IPT_OFF_TRAPIN 12'h018
`define IPT_OFF_PRIO0 12'h01C
`define IPT_OFF_PRIO1 12'h020
`define IPT_OFF_PRIO2 12'h024
`define IPT_LVL_LSB 5
`define IPT_EXT_BIT 3
`define IPT_NESTING_DISABLE_BIT 15
`define IPT_ALT_BIT 15
`define IPT_TIMED_DISABLE_ACTIVE_BIT 14
`define IPT_FLAGS0_MASK 16'h3E8F
`define IPT_FLAGS1_MASK 16'h201F
`define IPT_CTL1_WMASK 16'hFFDE
`define IPT_NUM_SRC 14
`define IPT_CTL1_RESET 16'h0000
`endif

// ### ipt_sync.v
`timescale 1ns/1ps
// Two-stage synchroniser for asynchronous pin levels
module ipt_sync #(
   parameter W = 3
) (
   input wire pclk,
   input wire presetn,
   input wire ce,
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
   reg [W-1:0] meta;
   // First stage feeds only the second
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= {W{1'b0}};
         q <= {W{1'b0}};
      end else if (ce) begin
         meta <= d;
         q <= meta;
      end
   end
endmodule // ipt_sync

// ### ipt_edge.v
`timescale 1ns/1ps
// Edge detector with selectable polarity per pin
module ipt_edge #(
   parameter W = 3
) (
   input wire pclk,
   input wire presetn,
   input wire ce,
   input wire [W-1:0] level,
   input wire [W-1:0] falling_sel,
   output wire [W-1:0] hit
);
   reg [W-1:0] prev;
   // Previous synchronised level
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev <= {W{1'b0}};
      end else if (ce) begin
         prev <= level;
      end
   end
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_edge
         // One selects falling, zero rising
         assign hit[i] = ce & (falling_sel[i] ? (prev[i] & ~level[i]) : (~prev[i] & level[i]));
      end
   endgenerate
endmodule // ipt_edge

// ### ipt_core.v
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ps
`include "ipt_regs.vh"
// Interrupt priority state, trap flags and request flags behind APB
module ipt_core #(
   parameter NSRC = `IPT_NUM_SRC
) (
   input wire pclk,
   input wire presetn,
   input wire ce,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [2:0] ext_pin,
   input wire [10:0] periph_req,
   input wire acc_a_overflow,
   input wire acc_b_overflow,
   input wire acc_a_catastrophic,
   input wire acc_b_catastrophic,
   input wire bad_shift,
   input wire divide_zero,
   input wire address_error,
   input wire stack_error,
   input wire oscillator_fail,
   input wire timed_disable_in,
   input wire trap_taken,
   input wire [3:0] trap_level,
   input wire [NSRC-1:0] source_enable,
   output reg irq_valid,
   output reg [3:0] irq_source,
   output reg [2:0] irq_level,
   output reg trap_valid,
   output reg alternate_table_select,
   output reg [3:0] cpu_level
);
   // Architectural state
   reg [2:0] cpu_level_low_field;
   reg cpu_level_extension;
   reg nesting_disable;
   reg acc_a_overflow_trap_flag, acc_b_overflow_trap_flag;
   reg acc_a_catastrophic_flag, acc_b_catastrophic_flag;
   reg acc_a_overflow_trap_enable, acc_b_overflow_trap_enable, catastrophic_trap_enable;
   reg bad_shift_cause, divide_zero_cause, math_trap_flag;
   reg address_trap_flag, stack_trap_flag, oscillator_trap_flag;
   reg timed_disable_active;
   reg [2:0] ext_falling_select;
   reg [15:0] flags0, flags1;
   reg [3*NSRC-1:0] src_prio;
   reg [15:0] next_rdata;
   reg next_pslverr;
   wire [2:0] ext_sync;
   wire [2:0] ext_hit;
   wire access = psel & penable & ce;
   wire wr = access & pwrite & ~pready;
   wire [15:0] wd = pwdata[15:0];
   wire [3:0] eff_level = {cpu_level_extension, cpu_level_low_field};
   // Accumulator trap causes gated by their enables
   wire ova_ev = acc_a_overflow & acc_a_overflow_trap_enable;
   wire ovb_ev = acc_b_overflow & acc_b_overflow_trap_enable;
   wire cova_ev = acc_a_catastrophic & catastrophic_trap_enable;
   wire covb_ev = acc_b_catastrophic & catastrophic_trap_enable;
   wire math_ev = bad_shift | divide_zero;
   wire any_trap = ova_ev | ovb_ev | cova_ev | covb_ev | math_ev | address_error | stack_error | oscillator_fail;

   ipt_sync #(.W(3)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .d(ext_pin),
      .q(ext_sync)
   );

   ipt_edge #(.W(3)) u_edge (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .level(ext_sync),
      .falling_sel(ext_falling_select),
      .hit(ext_hit)
   );

   // Hardware request vectors in register bit positions
   wire [15:0] set0 = {2'b00, periph_req[10:6], 1'b0, periph_req[5], 3'b000, periph_req[4:2], ext_hit[0]};
   // Bits 3 and 2 share the converter request; bits 1 and 0 are the two bus events
   wire [15:0] set1 = {2'b00, ext_hit[2], 8'h00, ext_hit[1], periph_req[10], periph_req[10], periph_req[1:0]};

   // Sources in natural order, lowest index wins ties
   // Fourteen arbitrated sources; the two late pin flags are status only
   wire [NSRC-1:0] pend = {flags1[3:0], flags0[13:9], flags0[7], flags0[3:0]};

   // APB write and hardware set logic; a set in the same cycle beats a clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_level_low_field <= 3'b000;
         cpu_level_extension <= 1'b0;
         nesting_disable <= 1'b0;
         {acc_a_overflow_trap_flag, acc_b_overflow_trap_flag} <= 2'b00;
         {acc_a_catastrophic_flag, acc_b_catastrophic_flag} <= 2'b00;
         {acc_a_overflow_trap_enable, acc_b_overflow_trap_enable, catastrophic_trap_enable} <= 3'b000;
         {bad_shift_cause, divide_zero_cause, math_trap_flag} <= 3'b000;
         {address_trap_flag, stack_trap_flag, oscillator_trap_flag} <= 3'b000;
         alternate_table_select <= 1'b0;
         timed_disable_active <= 1'b0;
         ext_falling_select <= 3'b000;
         flags0 <= 16'h0000;
         flags1 <= 16'h0000;
         src_prio <= {3*NSRC{1'b0}};
      end else if (ce) begin
         timed_disable_active <= timed_disable_in;
         // Status word: level field locked while nesting disabled
         if (wr && paddr == `IPT_OFF_STATUS && !nesting_disable) begin
            cpu_level_low_field <= wd[`IPT_LVL_LSB+2:`IPT_LVL_LSB];
         end
         // Extension bit: software may only clear it
         if (trap_taken) begin
            cpu_level_extension <= trap_level[3];
            cpu_level_low_field <= trap_level[2:0];
         end else if (wr && paddr == `IPT_OFF_CORE && !wd[`IPT_EXT_BIT]) begin
            cpu_level_extension <= 1'b0;
         end
         if (wr && paddr == `IPT_OFF_CTL1) begin
            nesting_disable <= wd[15];
            {acc_a_overflow_trap_flag, acc_b_overflow_trap_flag} <= wd[14:13];
            {acc_a_catastrophic_flag, acc_b_catastrophic_flag} <= wd[12:11];
            {acc_a_overflow_trap_enable, acc_b_overflow_trap_enable, catastrophic_trap_enable} <= wd[10:8];
            {bad_shift_cause, divide_zero_cause} <= wd[7:6];
            math_trap_flag <= wd[4];
            {address_trap_flag, stack_trap_flag, oscillator_trap_flag} <= wd[3:1];
         end
         // Trap causes set after any write of the same cycle
         if (ova_ev) acc_a_overflow_trap_flag <= 1'b1;
         if (ovb_ev) acc_b_overflow_trap_flag <= 1'b1;
         if (cova_ev) acc_a_catastrophic_flag <= 1'b1;
         if (covb_ev) acc_b_catastrophic_flag <= 1'b1;
         if (bad_shift) bad_shift_cause <= 1'b1;
         if (divide_zero) divide_zero_cause <= 1'b1;
         if (math_ev) math_trap_flag <= 1'b1;
         if (address_error) address_trap_flag <= 1'b1;
         if (stack_error) stack_trap_flag <= 1'b1;
         if (oscillator_fail) oscillator_trap_flag <= 1'b1;
         if (wr && paddr == `IPT_OFF_CTL2) begin
            alternate_table_select <= wd[`IPT_ALT_BIT];
            ext_falling_select <= wd[2:0];
         end
         // Flags: software writes, hardware sets win
         if (wr && paddr == `IPT_OFF_FLAGS0) begin
            flags0 <= (wd & `IPT_FLAGS0_MASK) | (set0 & `IPT_FLAGS0_MASK);
         end else begin
            flags0 <= flags0 | (set0 & `IPT_FLAGS0_MASK);
         end
         if (wr && paddr == `IPT_OFF_FLAGS1) begin
            flags1 <= (wd & `IPT_FLAGS1_MASK) | (set1 & `IPT_FLAGS1_MASK);
         end else begin
            flags1 <= flags1 | (set1 & `IPT_FLAGS1_MASK);
         end
         // Priorities, five sources per word, four in the third
         if (wr && paddr == `IPT_OFF_PRIO0) src_prio[14:0] <= wd[14:0];
         if (wr && paddr == `IPT_OFF_PRIO1) src_prio[29:15] <= wd[14:0];
         if (wr && paddr == `IPT_OFF_PRIO2) src_prio[3*NSRC-1:30] <= wd[3*NSRC-31:0];
      end
   end

   // Read mux; unmapped addresses answer with an error
   always @* begin
      next_rdata = 16'h0000;
      next_pslverr = 1'b0;
      case (paddr)
         `IPT_OFF_STATUS: next_rdata = {8'h00, cpu_level_low_field, 5'b00000};
         `IPT_OFF_CORE: next_rdata = {12'h000, cpu_level_extension, 3'b000};
         `IPT_OFF_CTL1: next_rdata = {nesting_disable, acc_a_overflow_trap_flag, acc_b_overflow_trap_flag,
            acc_a_catastrophic_flag, acc_b_catastrophic_flag, acc_a_overflow_trap_enable,
            acc_b_overflow_trap_enable, catastrophic_trap_enable, bad_shift_cause, divide_zero_cause,
            1'b0, math_trap_flag, address_trap_flag, stack_trap_flag, oscillator_trap_flag, 1'b0};
         `IPT_OFF_CTL2: next_rdata = {alternate_table_select, timed_disable_active, 11'h000, ext_falling_select};
         `IPT_OFF_FLAGS0: next_rdata = flags0;
         `IPT_OFF_FLAGS1: next_rdata = flags1;
         `IPT_OFF_TRAPIN: next_rdata = {15'h0000, any_trap};
         `IPT_OFF_PRIO0: next_rdata = {1'b0, src_prio[14:0]};
         `IPT_OFF_PRIO1: next_rdata = {1'b0, src_prio[29:15]};
         `IPT_OFF_PRIO2: next_rdata = {{(46-3*NSRC){1'b0}}, src_prio[3*NSRC-1:30]};
         default: next_pslverr = 1'b1;
      endcase
   end

   // Arbitration: highest priority, natural order breaks ties
   reg [3:0] best_src;
   reg [2:0] best_lvl;
   reg best_ok;
   integer k;
   always @* begin
      best_src = 4'h0;
      best_lvl = 3'b000;
      best_ok = 1'b0;
      for (k = NSRC - 1; k >= 0; k = k - 1) begin
         if (pend[k] && source_enable[k] && src_prio[3*k +: 3] >= best_lvl && src_prio[3*k +: 3] != 3'b000) begin
            best_src = k[3:0];
            best_lvl = src_prio[3*k +: 3];
            best_ok = 1'b1;
         end
      end
   end

   // APB answer is one wait state: pready rises in the cycle after setup-plus-access
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         irq_valid <= 1'b0;
         irq_source <= 4'h0;
         irq_level <= 3'b000;
         trap_valid <= 1'b0;
         cpu_level <= 4'h0;
      end else if (ce) begin
         pready <= access & ~pready;
         pslverr <= access & ~pready & next_pslverr;
         if (access && !pready) prdata <= {16'h0000, next_rdata};
         cpu_level <= eff_level;
         trap_valid <= any_trap;
         // Extension set blocks users; strict compare against full level
         irq_valid <= best_ok & ~cpu_level_extension & ({1'b0, best_lvl} > eff_level);
         irq_source <= best_src;
         irq_level <= best_lvl;
      end
   end
endmodule // ipt_core

// ### ipt_checker.sv
`timescale 1ns/1ps
// Watches the bus handshake and the priority outputs of the core
module ipt_checker (
   input wire pclk,
   input wire presetn,
   input wire ce,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire pready,
   input wire pslverr,
   input wire trap_taken,
   input wire [3:0] trap_level,
   input wire irq_valid,
   input wire [2:0] irq_level,
   input wire alternate_table_select,
   input wire [3:0] cpu_level
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // An access is taken once, at the edge before the single wait state ends
   sequence s_taken;
      psel && penable && !pready && ce;
   endsequence
   sequence s_ctl2_write;
      s_taken ##0 (pwrite && paddr == 12'h00C);
   endsequence
   a_ready_one_wait: assert property (s_taken |=> pready) else $error("ready missing after access");
   a_ready_one_pulse: assert property (pready |=> !pready) else $error("ready held too long");
   a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
   a_err_unmapped: assert property (s_taken ##0 (paddr > 12'h024) |=> pslverr) else $error("no error on hole");
   a_alt_follows_write: assert property (s_ctl2_write |=> alternate_table_select == $past(pwdata[15]))
      else $error("table select not written");
   a_alt_held: assert property (!(psel && penable && !pready && ce && pwrite && paddr == 12'h00C)
      |=> $stable(alternate_table_select))
      else $error("table select moved");
   a_trap_loads_level: assert property (trap_taken && ce |=> ##1 cpu_level == $past(trap_level, 2))
      else $error("trap level not loaded");
   a_ext_only_trap: assert property ($rose(cpu_level[3]) |-> $past(trap_taken, 2))
      else $error("extension set by software");
   a_ext_blocks_user: assert property (cpu_level[3] |-> !irq_valid)
      else $error("user request above level 7");
   a_irq_exceeds_level: assert property (irq_valid |-> {1'b0, irq_level} > cpu_level)
      else $error("request not above cpu level");
endmodule // ipt_checker
bind ipt_core ipt_checker u_chk (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .trap_taken(trap_taken),
   .trap_level(trap_level), .irq_valid(irq_valid), .irq_level(irq_level),
   .alternate_table_select(alternate_table_select), .cpu_level(cpu_level));

// ### ipt_source_model.sv
`timescale 1ns/1ps
// Peripherals and trap sources: one-cycle pulse per command
module ipt_source_model (
   input wire pclk,
   input wire presetn,
   input wire go,
   input wire [4:0] code,
   output reg [10:0] periph_req,
   output reg [8:0] cause
);
   // Codes below 11 are peripheral requests, codes 11 to 19 trap causes
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         periph_req <= 11'h000;
         cause <= 9'h000;
      end else begin
         periph_req <= (go && code < 5'h0B) ? 11'h001 << code : 11'h000;
         cause <= (go && code >= 5'h0B) ? 9'h001 << (code - 5'h0B) : 9'h000;
      end
   end
endmodule // ipt_source_model

// ### interrupt_priority_and_trap_flags_tb.sv
`timescale 1ns/1ps
module interrupt_priority_and_trap_flags_tb;
   logic pclk, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
   logic trap_taken = 0, timed_disable_in = 0, go = 0, irq_valid, alternate_table_select;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, fl;
   logic [2:0] ext_pin = 3'h0, irq_level;
   logic [3:0] trap_level = 4'h0, irq_source, cpu_level;
   logic [4:0] code = 5'h00;
   logic [13:0] source_enable = 14'h3FFF;
   logic [10:0] periph_req;
   logic [8:0] cause;
   logic [15:0] v;
   int bad_count = 0, n_checks = 0, i;
   ipt_core dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_pin(ext_pin),
      .periph_req(periph_req), .acc_a_overflow(cause[0]), .acc_b_overflow(cause[1]),
      .acc_a_catastrophic(cause[2]), .acc_b_catastrophic(cause[3]), .bad_shift(cause[4]),
      .divide_zero(cause[5]), .address_error(cause[6]), .stack_error(cause[7]), .oscillator_fail(cause[8]),
      .timed_disable_in(timed_disable_in), .trap_taken(trap_taken), .trap_level(trap_level),
      .source_enable(source_enable), .irq_valid(irq_valid), .irq_source(irq_source), .irq_level(irq_level),
      .trap_valid(), .alternate_table_select(alternate_table_select), .cpu_level(cpu_level));
   ipt_source_model src (.pclk(pclk), .presetn(presetn), .go(go), .code(code), .periph_req(periph_req),
      .cause(cause));
   // Clock at 25 MHz
   initial begin
      pclk = 0;
      forever #20 pclk = ~pclk;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Master waits for the answer instead of assuming the wait state
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
      if (n >= 50) bad_count++;
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task fire(input int c);
      @(posedge pclk);
      go <= 1;
      code <= c[4:0];
      @(posedge pclk);
      go <= 0;
   endtask
   task read_flags;
      apb(0, 12'h010, 0);
      fl = rd;
      apb(0, 12'h014, 0);
      fl = fl | (rd << 16);
      apb(1, 12'h010, 0);
      apb(1, 12'h014, 0);
   endtask
   function automatic logic [15:0] trap_bits(input int k);
      return k < 4 ? 16'h4000 >> k : k < 6 ? (16'h0080 >> (k - 4)) | 16'h0010 : 16'h0008 >> (k - 6);
   endfunction
   function automatic logic [31:0] req_bits(input int k);
      return k < 2 ? 32'h10000 << k : k < 5 ? 32'h1 << (k - 1) : k == 5 ? 32'h80 : k < 10 ? 32'h1 << (k + 3)
         : 32'h000C2000;
   endfunction
   task complete_run;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Watchdog cuts a hung handshake short
   initial begin
      repeat (20000) @(posedge pclk);
      bad_count++;
      complete_run;
   end
   // Main sequence
   initial begin
      v = $urandom(32'h38bc333b);
      repeat (10) @(posedge pclk);
      presetn <= 1;
      for (i = 0; i < 6; i++) begin
         apb(0, 12'(i * 4), 0);
         chk(rd, 0);
      end
      apb(0, 12'h030, 0);
      chk(32'(er), 1);
      $display("reset test done");
      v = $urandom;
      apb(1, 12'h000, 32'(v[2:0]) << 5);
      apb(0, 12'h000, 0);
      chk(rd, 32'(v[2:0]) << 5);
      chk(32'(cpu_level), 32'(v[2:0]));
      apb(1, 12'h008, 32'h8000);
      apb(1, 12'h000, 32'(~v[2:0]) << 5);
      apb(0, 12'h000, 0);
      chk(rd, 32'(v[2:0]) << 5);
      apb(0, 12'h008, 0);
      chk(rd, 32'h8000);
      $display("level test done");
      for (i = 0; i < 9; i++) begin
         apb(1, 12'h008, 32'h0700);
         fire(i + 11);
         apb(0, 12'h008, 0);
         chk(rd, 32'h0700 | trap_bits(i));
      end
      apb(1, 12'h008, 0);
      for (i = 11; i < 15; i++) fire(i);
      apb(0, 12'h008, 0);
      chk(rd, 0);
      $display("trap test done");
      for (i = 0; i < 2; i++) begin
         v = $urandom;
         v[15] = i[0];
         timed_disable_in <= i[0];
         apb(1, 12'h00C, 32'(v & 16'hC007));
         apb(0, 12'h00C, 0);
         chk(rd, 32'(v & 16'h8007) | (32'(i) << 14));
         chk(32'(alternate_table_select), 32'(i));
      end
      for (i = 0; i < 11; i++) begin
         fire(i);
         read_flags;
         chk(fl, req_bits(i));
      end
      for (i = 0; i < 3; i++) begin
         apb(1, 12'h00C, 32'h1 << i);
         ext_pin[i] <= 1;
         repeat (5) @(posedge pclk);
         read_flags;
         chk(fl, 0);
         ext_pin[i] <= 0;
         repeat (5) @(posedge pclk);
         read_flags;
         chk(fl, i == 0 ? 32'h1 : i == 1 ? 32'h00100000 : 32'h20000000);
      end
      $display("flag test done");
      apb(1, 12'h00C, 0);
      apb(1, 12'h01C, 32'h5);
      apb(1, 12'h010, 32'h1);
      for (i = 0; i < 8; i++) begin
         apb(1, 12'h000, 32'(i) << 5);
         repeat (3) @(posedge pclk);
         chk(32'(irq_valid), 32'(i < 5));
      end
      apb(1, 12'h000, 0);
      repeat (3) @(posedge pclk);
      chk({irq_source, 1'b0, irq_level}, 32'h05);
      trap_taken <= 1;
      trap_level <= 4'hB;
      @(posedge pclk);
      trap_taken <= 0;
      repeat (3) @(posedge pclk);
      chk(32'(irq_valid), 0);
      apb(0, 12'h004, 0);
      chk(rd & 32'h8, 32'h8);
      apb(1, 12'h004, 0);
      apb(1, 12'h004, 32'h8);
      apb(0, 12'h004, 0);
      chk(rd & 32'h8, 0);
      $display("priority test done");
      complete_run;
   end
endmodule // interrupt_priority_and_trap_flags_tb
